//--- rtl/cxt_pkg.sv
// constants, opcodes and register map of the transfer/skip execution core
// assumes one 10 MHz clock and a classic wishbone slave port
// Function
// - a skip-capable op that does not skip adds no machine cycles
// - skipping a one or two byte instruction costs one extra machine cycle
// - skipping a three byte instruction costs two extra machine cycles
// - skipping the indirect table call always costs exactly one machine cycle
// - one machine cycle is one cpu clock period, five selectable periods
// - accesses through DE or DL always use memory bank 0
// - bit addressing in peripheral and port areas always uses bank 15
// - eight 4-bit registers, paired as XA, BC, DE, HL 8-bit accumulators
// - a second set of four extended pairs, addressable separately
// - the carry bit acts as one-bit accumulator for bit transfers
// - load A from HL then increment L, 2+S cycles, skip when L wraps to 0
// - post-decrement move or exchange through HL, skip when L becomes FH
// - exchange A with HL memory then increment L, skip when L wraps to 0
// - page table read loads XA from ROM at PC bits 14-8 plus DE or XA, 3 cycles
// - consecutive immediate loads of the same group: only the first executes
package cxt_pkg;
	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_CMD = 8'h04;
	localparam logic [7:0] ADR_GPR = 8'h08;
	localparam logic [7:0] ADR_EXT = 8'h0c;
	localparam logic [7:0] ADR_STAT = 8'h10;
	localparam logic [7:0] ADR_CARRY = 8'h14;
	localparam logic [7:0] ADR_PC = 8'h18;
	// ctrl fields
	localparam int CTRL_PCS_LSB = 0;
	localparam int CTRL_SCS_BIT = 2;
	localparam int CTRL_MBE_BIT = 4;
	localparam int CTRL_MBS_LSB = 8;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	// cmd fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_NLEN_LSB = 8;
	localparam int CMD_NTBL_BIT = 10;
	localparam int CMD_EXT_BIT = 11;
	localparam int CMD_SEL_LSB = 12;
	localparam int CMD_IMM_LSB = 16;
	localparam int CMD_MEM_LSB = 24;
	// gpr nibble slots in the gpr word
	localparam int R_A = 0;
	localparam int R_X = 1;
	localparam int R_C = 2;
	localparam int R_B = 3;
	localparam int R_E = 4;
	localparam int R_D = 5;
	localparam int R_L = 6;
	localparam int R_H = 7;
	// fixed banks and machine cycle dividers in clk cycles
	localparam logic [3:0] BANK_PAIR = 4'h0;
	localparam logic [3:0] BANK_FIXED = 4'hf;
	localparam logic [7:0] DIV_PCS0 = 8'h40;
	localparam logic [7:0] DIV_PCS1 = 8'h10;
	localparam logic [7:0] DIV_PCS2 = 8'h08;
	localparam logic [7:0] DIV_PCS3 = 8'h04;
	localparam logic [7:0] DIV_SYS = 8'h80;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		OP_NOP, OP_MOV_A_N4, OP_MOV_XA_N8, OP_MOV_HL_N8, OP_MOV_A_HL, OP_MOV_A_HLI,
		OP_MOV_A_HLD, OP_XCH_A_HL, OP_XCH_A_HLI, OP_XCH_A_HLD, OP_MOV_A_DE,
		OP_MOV_A_DL, OP_MOV_HL_A, OP_XCH_XA_RP, OP_TBL_PCDE, OP_TBL_PCXA,
		OP_TBL_BCDE, OP_TBL_BCXA, OP_BIT_LOAD, OP_BIT_STORE
	} cxt_op_t;
	typedef enum logic [1:0] {GRP_NONE, GRP_A, GRP_B} cxt_grp_t;
	typedef enum {ST_IDLE, ST_ALIGN, ST_EXEC, ST_SKIP} cxt_state_t;
endpackage : cxt_pkg

//--- rtl/cxt_core.sv
// transfer, exchange and table read execution core with skip timing
// assumes synchronous rom/ram answering two clk after a read strobe
`timescale 1ns/1ns
module cxt_core import cxt_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// data ram
	output logic [11:0] ramAddr,
	output logic ramRd,
	output logic ramWe,
	output logic [3:0] ramWdata,
	input wire logic [3:0] ramRdata,
	// program rom
	output logic [14:0] romAddr,
	output logic romRd,
	input wire logic [7:0] romData
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d, cmd_q, cmd_d;
	logic [7:0][3:0] gpr_q, gpr_d;
	logic [3:0][7:0] ext_q, ext_d;
	logic [14:0] pc_q, pc_d;
	logic carry_q, carry_d, skip_q, skip_d, nop_q, nop_d;
	cxt_state_t state_q, state_d;
	cxt_grp_t grp_q, grp_d;
	logic [1:0] cnt_q, cnt_d, skipCyc_q, skipCyc_d;
	logic [2:0] last_q, last_d;
	logic [7:0] div_q, div_d, divLim;
	logic [11:0] ramAddr_d;
	logic [14:0] romAddr_d;
	logic ramRd_d, romRd_d, ramWe_d;
	logic [3:0] ramWdata_d;
	logic ack_q, ack_d;
	logic [31:0] dat_d;
	logic cycEn, busWr, busRd, start, commit, skipTake;
	logic [1:0] base, skipLen;
	cxt_op_t op;
	cxt_grp_t grp;
	logic [3:0] bank, lNext;

	assign op = cxt_op_t'(cmd_q[CMD_OP_LSB +: 5]);
	assign busRd = wb_cyc_i & wb_stb_i & ~ack_q;
	assign busWr = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
	assign wb_ack_o = ack_q;

	// ----------------------------------------------------------------
	// machine cycle divider
	// ----------------------------------------------------------------
	// five cpu clock periods; smallest is four clk so memory data settles
	always_comb begin
		if (ctrl_q[CTRL_SCS_BIT]) begin
			divLim = DIV_SYS;
		end else begin
			case (ctrl_q[CTRL_PCS_LSB +: 2])
				2'h0: divLim = DIV_PCS0;
				2'h1: divLim = DIV_PCS1;
				2'h2: divLim = DIV_PCS2;
				default: divLim = DIV_PCS3;
			endcase
		end
		cycEn = (div_q >= divLim - 8'h01);
		div_d = cycEn ? 8'h00 : div_q + 8'h01;
	end

	// ----------------------------------------------------------------
	// per-op decode
	// ----------------------------------------------------------------
	// base cycles equal byte count except auto step (2) and table reads (3)
	always_comb begin
		base = 2'h1;
		grp = GRP_NONE;
		case (op)
			OP_MOV_A_N4: grp = GRP_A;
			OP_MOV_XA_N8: begin
				base = 2'h2;
				grp = GRP_A;
			end
			OP_MOV_HL_N8: begin
				base = 2'h2;
				grp = GRP_B;
			end
			OP_MOV_A_HLI, OP_MOV_A_HLD, OP_XCH_A_HLI, OP_XCH_A_HLD: base = 2'h2;
			OP_XCH_XA_RP, OP_BIT_LOAD, OP_BIT_STORE: base = 2'h2;
			OP_TBL_PCDE, OP_TBL_PCXA, OP_TBL_BCDE, OP_TBL_BCXA: base = 2'h3;
			default: base = 2'h1;
		endcase
		// HL access uses the selected bank only when banking is enabled
		bank = ctrl_q[CTRL_MBE_BIT] ? ctrl_q[CTRL_MBS_LSB +: 4] : 4'h0;
		case (op)
			OP_MOV_A_DE: ramAddr_d = {BANK_PAIR, gpr_q[R_D], gpr_q[R_E]};
			OP_MOV_A_DL: ramAddr_d = {BANK_PAIR, gpr_q[R_D], gpr_q[R_L]};
			OP_BIT_LOAD, OP_BIT_STORE: begin
				ramAddr_d = {BANK_FIXED, cmd_q[CMD_MEM_LSB +: 8]};
			end
			default: ramAddr_d = {bank, gpr_q[R_H], gpr_q[R_L]};
		endcase
		case (op)
			OP_TBL_PCDE: romAddr_d = {pc_q[14:8], gpr_q[R_D], gpr_q[R_E]};
			OP_TBL_PCXA: romAddr_d = {pc_q[14:8], gpr_q[R_X], gpr_q[R_A]};
			OP_TBL_BCDE: romAddr_d = {gpr_q[R_B][2:0], gpr_q[R_C], gpr_q[R_D], gpr_q[R_E]};
			default: romAddr_d = {gpr_q[R_B][2:0], gpr_q[R_C], gpr_q[R_X], gpr_q[R_A]};
		endcase
	end

	// ----------------------------------------------------------------
	// execution sequencer and register file
	// ----------------------------------------------------------------
	// bus writes to registers are ignored while an op runs
	always_comb begin
		ctrl_d = ctrl_q;
		cmd_d = cmd_q;
		gpr_d = gpr_q;
		ext_d = ext_q;
		pc_d = pc_q;
		carry_d = carry_q;
		skip_d = skip_q;
		nop_d = nop_q;
		state_d = state_q;
		grp_d = grp_q;
		cnt_d = cnt_q;
		skipCyc_d = skipCyc_q;
		last_d = last_q;
		ramRd_d = 1'b0;
		romRd_d = 1'b0;
		ramWe_d = 1'b0;
		ramWdata_d = ramWdata;
		skipTake = 1'b0;
		lNext = gpr_q[R_L];
		start = busWr && wb_adr_i == ADR_CMD && state_q == ST_IDLE;
		commit = state_q == ST_EXEC && cycEn && cnt_q == base;
		skipLen = cmd_q[CMD_NLEN_LSB +: 2];
		if (busWr && state_q == ST_IDLE) begin
			for (int i = 0; i < 4; i++) begin
				if (wb_sel_i[i]) begin
					case (wb_adr_i)
						ADR_CTRL: ctrl_d[8*i +: 8] = wb_dat_i[8*i +: 8];
						ADR_CMD: cmd_d[8*i +: 8] = wb_dat_i[8*i +: 8];
						ADR_GPR: gpr_d[2*i +: 2] = wb_dat_i[8*i +: 8];
						ADR_EXT: ext_d[i] = wb_dat_i[8*i +: 8];
						default: ;
					endcase
				end
			end
			if (wb_adr_i == ADR_CARRY && wb_sel_i[0]) carry_d = wb_dat_i[0];
			if (wb_adr_i == ADR_PC && wb_sel_i[0]) pc_d[7:0] = wb_dat_i[7:0];
			if (wb_adr_i == ADR_PC && wb_sel_i[1]) pc_d[14:8] = wb_dat_i[14:8];
		end
		case (state_q)
			ST_IDLE: if (start) begin
				state_d = ST_ALIGN;
				skip_d = 1'b0;
			end
			ST_ALIGN: if (cycEn) begin
				// repeated load of the same group runs as a no-operation
				nop_d = grp != GRP_NONE && grp == grp_q;
				grp_d = grp;
				ramRd_d = op inside {OP_MOV_A_HL, OP_MOV_A_HLI, OP_MOV_A_HLD, OP_XCH_A_HL,
					OP_XCH_A_HLI, OP_XCH_A_HLD, OP_MOV_A_DE, OP_MOV_A_DL, OP_BIT_LOAD,
					OP_BIT_STORE};
				romRd_d = op inside {OP_TBL_PCDE, OP_TBL_PCXA, OP_TBL_BCDE, OP_TBL_BCXA};
				cnt_d = 2'h1;
				state_d = ST_EXEC;
			end
			ST_EXEC: if (commit) begin
				lNext = gpr_q[R_L];
				case (op)
					OP_MOV_A_N4: if (!nop_q) gpr_d[R_A] = cmd_q[CMD_IMM_LSB +: 4];
					OP_MOV_XA_N8: if (!nop_q) gpr_d[R_A +: 2] = cmd_q[CMD_IMM_LSB +: 8];
					OP_MOV_HL_N8: if (!nop_q) gpr_d[R_L +: 2] = cmd_q[CMD_IMM_LSB +: 8];
					OP_MOV_A_HL, OP_MOV_A_DE, OP_MOV_A_DL: gpr_d[R_A] = ramRdata;
					OP_MOV_A_HLI: begin
						gpr_d[R_A] = ramRdata;
						lNext = gpr_q[R_L] + 4'h1;
						skipTake = lNext == 4'h0;
					end
					OP_MOV_A_HLD: begin
						gpr_d[R_A] = ramRdata;
						lNext = gpr_q[R_L] - 4'h1;
						skipTake = lNext == 4'hf;
					end
					OP_XCH_A_HL, OP_XCH_A_HLI, OP_XCH_A_HLD: begin
						gpr_d[R_A] = ramRdata;
						ramWdata_d = gpr_q[R_A];
						ramWe_d = 1'b1;
						if (op == OP_XCH_A_HLI) begin
							lNext = gpr_q[R_L] + 4'h1;
							skipTake = lNext == 4'h0;
						end else if (op == OP_XCH_A_HLD) begin
							lNext = gpr_q[R_L] - 4'h1;
							skipTake = lNext == 4'hf;
						end
					end
					OP_MOV_HL_A: begin
						ramWdata_d = gpr_q[R_A];
						ramWe_d = 1'b1;
					end
					OP_XCH_XA_RP: begin
						// pair select 0..3 is XA BC DE HL, ext bit picks the primed set
						if (cmd_q[CMD_EXT_BIT]) begin
							gpr_d[R_A +: 2] = ext_q[cmd_q[CMD_SEL_LSB +: 2]];
							ext_d[cmd_q[CMD_SEL_LSB +: 2]] = {gpr_q[R_X], gpr_q[R_A]};
						end else begin
							gpr_d[R_A +: 2] = gpr_q[2*cmd_q[CMD_SEL_LSB +: 2] +: 2];
							gpr_d[2*cmd_q[CMD_SEL_LSB +: 2] +: 2] = gpr_q[R_A +: 2];
						end
					end
					OP_TBL_PCDE, OP_TBL_PCXA, OP_TBL_BCDE, OP_TBL_BCXA: begin
						gpr_d[R_A +: 2] = romData;
					end
					OP_BIT_LOAD: carry_d = ramRdata[cmd_q[CMD_SEL_LSB +: 2]];
					OP_BIT_STORE: begin
						ramWdata_d = ramRdata;
						ramWdata_d[cmd_q[CMD_SEL_LSB +: 2]] = carry_q;
						ramWe_d = 1'b1;
					end
					default: ;
				endcase
				// only a stepping op moves L; a pair load of HL must keep its new L
				if (lNext != gpr_q[R_L]) gpr_d[R_L] = lNext;
				skip_d = skipTake;
				// table call skips in one cycle, a three byte op in two
				if (cmd_q[CMD_NTBL_BIT]) skipCyc_d = 2'h1;
				else if (skipLen == 2'h3) skipCyc_d = 2'h2;
				else skipCyc_d = 2'h1;
				if (!skipTake) skipCyc_d = 2'h0;
				last_d = {1'b0, base};
				cnt_d = 2'h1;
				state_d = skipTake ? ST_SKIP : ST_IDLE;
			end else if (cycEn) begin
				cnt_d = cnt_q + 2'h1;
			end
			ST_SKIP: if (cycEn) begin
				if (cnt_q == skipCyc_q) begin
					last_d = 3'({1'b0, base} + {1'b0, skipCyc_q});
					state_d = ST_IDLE;
				end else begin
					cnt_d = cnt_q + 2'h1;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// ----------------------------------------------------------------
	// bus answer
	// ----------------------------------------------------------------
	// one wait state: data latched with ack, unmapped reads return zero
	always_comb begin
		ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
		dat_d = wb_dat_o;
		if (busRd) begin
			case (wb_adr_i)
				ADR_CTRL: dat_d = ctrl_q;
				ADR_CMD: dat_d = cmd_q;
				ADR_GPR: dat_d = gpr_q;
				ADR_EXT: dat_d = ext_q;
				ADR_STAT: dat_d = {20'h0, bank, 1'b0, last_q, skip_q, carry_q,
					nop_q, state_q != ST_IDLE};
				ADR_CARRY: dat_d = {31'h0, carry_q};
				ADR_PC: dat_d = {17'h0, pc_q};
				default: dat_d = 32'h0;
			endcase
		end
	end

	// registers
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q <= CTRL_RESET;
			cmd_q <= 32'h0;
			gpr_q <= '0;
			ext_q <= '0;
			pc_q <= 15'h0;
			carry_q <= 1'b0;
			skip_q <= 1'b0;
			nop_q <= 1'b0;
			state_q <= ST_IDLE;
			grp_q <= GRP_NONE;
			cnt_q <= 2'h0;
			skipCyc_q <= 2'h0;
			last_q <= 3'h0;
			div_q <= 8'h0;
			ramAddr <= 12'h0;
			romAddr <= 15'h0;
			ramRd <= 1'b0;
			romRd <= 1'b0;
			ramWe <= 1'b0;
			ramWdata <= 4'h0;
			ack_q <= 1'b0;
			wb_dat_o <= 32'h0;
		end else begin
			ctrl_q <= ctrl_d;
			cmd_q <= cmd_d;
			gpr_q <= gpr_d;
			ext_q <= ext_d;
			pc_q <= pc_d;
			carry_q <= carry_d;
			skip_q <= skip_d;
			nop_q <= nop_d;
			state_q <= state_d;
			grp_q <= grp_d;
			cnt_q <= cnt_d;
			skipCyc_q <= skipCyc_d;
			last_q <= last_d;
			div_q <= div_d;
			ramAddr <= (state_q == ST_ALIGN) ? ramAddr_d : ramAddr;
			romAddr <= (state_q == ST_ALIGN) ? romAddr_d : romAddr;
			ramRd <= ramRd_d;
			romRd <= romRd_d;
			ramWe <= ramWe_d;
			ramWdata <= ramWdata_d;
			ack_q <= ack_d;
			wb_dat_o <= dat_d;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_noskip_no_cycles: assert property (commit && !skipTake |=> state_q == ST_IDLE && !skip_q)
		else $error("non-skipping op took extra cycles");
	a_skip_short_one: assert property (commit && skipTake && !cmd_q[CMD_NTBL_BIT] && skipLen != 2'h3 |=> skipCyc_q == 2'h1)
		else $error("short skip not one cycle");
	a_skip_long_two: assert property (commit && skipTake && !cmd_q[CMD_NTBL_BIT] && skipLen == 2'h3 |=> skipCyc_q == 2'h2)
		else $error("long skip not two cycles");
	a_skip_table_one: assert property (commit && skipTake && cmd_q[CMD_NTBL_BIT] |=> skipCyc_q == 2'h1)
		else $error("table call skip not one cycle");
	a_mcycle_spacing: assert property (cycEn |=> !cycEn [*3])
		else $error("machine cycle shorter than four clocks");
	a_pair_bank_zero: assert property (ramRd && op inside {OP_MOV_A_DE, OP_MOV_A_DL} |-> ramAddr[11:8] == BANK_PAIR)
		else $error("DE/DL access left bank 0");
	a_fixed_bank_15: assert property (ramRd && op inside {OP_BIT_LOAD, OP_BIT_STORE} |-> ramAddr[11:8] == BANK_FIXED)
		else $error("bit access left bank 15");
	a_inc_wrap_skip: assert property (commit && op inside {OP_MOV_A_HLI, OP_XCH_A_HLI} && gpr_q[R_L] == 4'hf |=> skip_q && gpr_q[R_L] == 4'h0)
		else $error("increment wrap did not skip");
	a_dec_wrap_skip: assert property (commit && op inside {OP_MOV_A_HLD, OP_XCH_A_HLD} && gpr_q[R_L] == 4'h0 |=> skip_q && gpr_q[R_L] == 4'hf)
		else $error("decrement wrap did not skip");
	a_xch_write_back: assert property (commit && op == OP_XCH_A_HLI |=> ramWe && ramWdata == $past(gpr_q[R_A]))
		else $error("exchange did not write A back");
	a_table_three: assert property (commit && op inside {OP_TBL_PCDE, OP_TBL_PCXA, OP_TBL_BCDE, OP_TBL_BCXA} |-> cnt_q == 2'h3)
		else $error("table read not three cycles");

	c_skip_taken: cover property (state_q == ST_SKIP && state_d == ST_IDLE);
	c_string_nop: cover property (commit && nop_q);
	c_table_read: cover property (romRd);
	c_exchange_ext: cover property (commit && op == OP_XCH_XA_RP && cmd_q[CMD_EXT_BIT]);
endmodule : cxt_core

//--- verification/cxt_mem.sv
// program rom and data ram on the far side of the transfer core
// assumes registered one-clk read strobes from the core
`timescale 1ns/1ns
module cxt_mem (
	// clock
	input wire logic clk,
	// data ram
	input wire logic [11:0] ramAddr,
	input wire logic ramRd,
	input wire logic ramWe,
	input wire logic [3:0] ramWdata,
	output logic [3:0] ramRdata,
	// program rom
	input wire logic [14:0] romAddr,
	input wire logic romRd,
	output logic [7:0] romData
);
	logic [3:0] ram [4096];
	logic [11:0] ra;
	logic [14:0] pa;
	logic rp, pp;
	// ----
	// bank-dependent fill, so a wrong bank reads a wrong nibble
	// ----
	initial begin
		for (int i = 0; i < 4096; i++) ram[i] = 4'(i ^ (i >> 4) ^ (i >> 8));
		{ramRdata, romData, rp, pp} = '0;
	end
	// answer two clk after a strobe; inverse meanwhile, so early sampling is caught
	always @(posedge clk) begin
		rp <= ramRd;
		pp <= romRd;
		if (ramRd) begin
			ra <= ramAddr;
			ramRdata <= ~ramRdata;
		end
		if (romRd) begin
			pa <= romAddr;
			romData <= ~romData;
		end
		if (rp) ramRdata <= ram[ra];
		if (pp) romData <= pa[7:0] ^ {1'b0, pa[14:8]};
		if (ramWe) ram[ramAddr] <= ramWdata;
	end
endmodule : cxt_mem

//--- verification/tb.sv
// self-checking bench for the transfer/skip core
// assumes the rom/ram model answers two clk after a strobe
`timescale 1ns/1ns
module tb import cxt_pkg::*;;
	logic clk = 0, reset = 1, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = '0;
	logic [3:0] sel = '0;
	logic [31:0] datI = '0, datO, g, e, q;
	logic ack, ramRd, ramWe, romRd, inc, nt;
	logic [11:0] ramAddr, ad;
	logic [3:0] ramWdata, ramRdata, l, a0, m;
	logic [14:0] romAddr, pc;
	logic [7:0] romData, x;
	logic [15:0] w;
	logic [4:0] o;
	logic [1:0] len, sl;
	logic [4:0] opsA [4] = '{5'd5, 5'd6, 5'd8, 5'd9};
	int dvs [5] = '{DIV_PCS0, DIV_PCS1, DIV_PCS2, DIV_PCS3, DIV_SYS};
	int bad_count = 0, total_checks = 0, clkCnt = 0, dv = 4;
	always #50 clk = ~clk;
	always @(posedge clk) clkCnt++;
	cxt_core u_cxt_core (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(datO),
		.wb_ack_o(ack), .ramAddr(ramAddr), .ramRd(ramRd), .ramWe(ramWe),
		.ramWdata(ramWdata), .ramRdata(ramRdata), .romAddr(romAddr), .romRd(romRd),
		.romData(romData));
	cxt_mem u_cxt_mem (.clk(clk), .ramAddr(ramAddr), .ramRd(ramRd), .ramWe(ramWe),
		.ramWdata(ramWdata), .ramRdata(ramRdata), .romAddr(romAddr), .romRd(romRd),
		.romData(romData));
	// ----
	// tasks
	// ----
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic note(input string s);
		$display("test %s done", s);
	endtask : note
	// one classic cycle; request held until the rising edge that samples ack high
	task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		datI <= d;
		sel <= 4'hf;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) bad_count++;
		q = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	// start an op, poll busy, check cycles, skip and duration, then read gpr
	task automatic run(input logic [4:0] op, input logic [7:0] im, input logic [1:0] s2,
		input logic ex, input logic tb1, input logic [1:0] ln, input logic [7:0] mm,
		input int base, input logic sk);
		int t, s;
		s = !sk ? 0 : (tb1 || ln != 2'd3) ? 1 : 2;
		wb(1'b1, ADR_CMD, {mm, im, 2'b00, s2, ex, tb1, ln, 3'b000, op});
		t = clkCnt;
		do wb(1'b0, ADR_STAT, '0); while (q[0] !== 1'b0 && clkCnt - t < 2000);
		t = clkCnt - t;
		chk(q[0], 1'b0);
		chk(q[6:3], {3'(base + s), sk});
		chk(t >= (base + s) * dv && t <= (base + s + 1) * dv + 12, 1);
		wb(1'b0, ADR_GPR, '0);
	endtask : run
	task automatic close_out;
		$display("checks %0d, mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : close_out
	// watchdog well beyond the longest expected run
	initial begin
		repeat (30000) @(posedge clk);
		bad_count++;
		close_out;
	end
	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(45942));
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		wb(1'b0, ADR_CTRL, '0);
		chk(q, CTRL_RESET);
		wb(1'b1, 8'h1c, 32'hffff_ffff);
		wb(1'b0, 8'h1c, '0);
		chk(q, '0);
		note("reset");
		// fastest period, bank enable on with bank 2
		wb(1'b1, ADR_CTRL, 32'h0000_0213);
		dv = DIV_PCS3;
		g = $urandom;
		e = $urandom;
		wb(1'b1, ADR_GPR, g);
		wb(1'b1, ADR_EXT, e);
		wb(1'b0, ADR_GPR, '0);
		chk(q, g);
		wb(1'b0, ADR_EXT, '0);
		chk(q, e);
		// post step ops at the wrap value first, then mid value
		for (int k = 0; k < 8; k++) begin
			o = opsA[k % 4];
			inc = (o == 5'd5 || o == 5'd8);
			l = k < 4 ? (inc ? 4'hf : 4'h0) : 4'h7;
			g[R_L*4 +: 4] = l;
			wb(1'b1, ADR_GPR, g);
			ad = {4'h2, g[R_H*4 +: 4], l};
			m = u_cxt_mem.ram[ad];
			a0 = g[3:0];
			nt = k[0];
			len = k < 2 ? 2'd3 : 2'($urandom_range(1, 3));
			run(o, '0, '0, 1'b0, nt, len, '0, 2, k < 4);
			g[3:0] = m;
			g[R_L*4 +: 4] = inc ? l + 4'h1 : l - 4'h1;
			chk(q, g);
			if (o > 5'd7) chk(u_cxt_mem.ram[ad], a0);
		end
		note("post step");
		for (int k = 0; k < 2; k++) begin
			ad = {4'h0, g[R_D*4 +: 4], k ? g[R_L*4 +: 4] : g[R_E*4 +: 4]};
			g[3:0] = u_cxt_mem.ram[ad];
			run(5'(10 + k), '0, '0, 1'b0, 1'b0, 2'd1, '0, 1, 1'b0);
			chk(q, g);
		end
		sl = 2'($urandom_range(1, 3));
		run(5'd13, '0, sl, 1'b1, 1'b0, 2'd1, '0, 2, 1'b0);
		{g[7:0], e[sl*8 +: 8]} = {e[sl*8 +: 8], g[7:0]};
		chk(q, g);
		wb(1'b0, ADR_EXT, '0);
		chk(q, e);
		note("pairs");
		pc = 15'($urandom);
		wb(1'b1, ADR_PC, {17'h0, pc});
		for (int k = 14; k < 18; k++) begin
			o = 5'(k);
			w = {o[4] ? g[15:8] : {1'b0, pc[14:8]}, o[0] ? g[7:0] : g[23:16]};
			run(o, '0, '0, 1'b0, 1'b0, 2'd1, '0, 3, 1'b0);
			g[7:0] = w[7:0] ^ {1'b0, w[14:8]};
			chk(q, g);
		end
		note("table");
		x = {7'($urandom), 1'b0};
		sl = 2'($urandom);
		run(5'd18, '0, sl, 1'b0, 1'b0, 2'd2, x, 2, 1'b0);
		m = u_cxt_mem.ram[{4'hf, x}];
		wb(1'b0, ADR_CARRY, '0);
		chk(q[0], m[sl]);
		// store the carry into one bit of an even fixed-bank address
		x = $urandom;
		wb(1'b1, ADR_CARRY, {24'h0, x});
		ad = {4'hf, x[7:1], 1'b0};
		m = u_cxt_mem.ram[ad];
		m[sl] = x[0];
		run(5'd19, '0, sl, 1'b0, 1'b0, 2'd2, {x[7:1], 1'b0}, 2, 1'b0);
		chk(u_cxt_mem.ram[ad], m);
		// second group-A load is swallowed, group B still runs
		x = $urandom;
		run(5'd2, x, '0, 1'b0, 1'b0, 2'd1, '0, 2, 1'b0);
		g[7:0] = x;
		run(5'd1, ~x, '0, 1'b0, 1'b0, 2'd1, '0, 1, 1'b0);
		chk(q, g);
		run(5'd3, ~x, '0, 1'b0, 1'b0, 2'd1, '0, 2, 1'b0);
		g[31:24] = ~x;
		chk(q, g);
		note("bits and string");
		for (int k = 0; k < 5; k++) begin
			wb(1'b1, ADR_CTRL, k < 4 ? 32'(k) : 32'h4);
			dv = dvs[k];
			run(5'd4, '0, '0, 1'b0, 1'b0, 2'd1, '0, 1, 1'b0);
		end
		note("periods");
		close_out;
	end
endmodule : tb
